// File: src/sar_abort_reporter.sv
// Operation
// RULE_01 - abort response carries four-byte abort code
// RULE_02 - failed transfer aborted, no normal reply
// RULE_03 - faults raise an emergency message
// RULE_04 - segment toggle must alternate, else abort
// RULE_05 - codes for command, timeout, memory faults
// RULE_06 - codes for access, write-only, read-only faults
// RULE_07 - codes for missing index and subindex
// RULE_08 - codes for unmappable object, mapping overflow
// RULE_09 - codes for data too long, too short
// RULE_10 - codes for range, above max, below min
// RULE_11 - code for maximum below minimum
// RULE_12 - general and application storage codes
// RULE_13 - code sent LSB first after index echo
`timescale 1ns/1ns
`default_nettype none
module sar_abort_reporter #(
    parameter int unsigned TIMEOUT_CYC = sar_pkg::TIMEOUT_CYC
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic req_valid,
    output logic req_ready,
    input wire sar_pkg::sar_req_t req,
    input wire sar_pkg::sar_chk_t chk,
    output logic resp_ok,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [7:0] tx_data,
    input wire logic comm_fault,
    input wire logic drive_fault,
    output logic emcy_valid,
    input wire logic emcy_ready,
    output logic [1:0] emcy_src
);

    // ----------------------------------------------------------------
    // request decode
    // ----------------------------------------------------------------
    typedef enum logic {ST_IDLE, ST_SEND} sar_state_t;

    sar_state_t state_q;
    logic seg_active_q;
    logic toggle_exp_q;
    logic [31:0] timer_q;
    logic [63:0] frame_q;
    logic [2:0] byte_cnt_q;
    logic [31:0] code_q;
    logic [15:0] index_q;
    logic [7:0] sub_q;
    logic resp_ok_q;
    logic [1:0] fault_q;
    logic emcy_valid_q;
    logic [1:0] emcy_src_q;

    logic take;
    logic is_seg;
    logic is_init;
    logic is_client_abort;
    logic timed_out;
    logic tx_take;
    logic err_any;
    logic [31:0] err_code;
    sar_pkg::sar_local_t loc;
    sar_pkg::sar_chk_t chk_eff;

    assign req_ready = (state_q == ST_IDLE);
    assign take = req_valid && req_ready;
    assign is_seg = (req.ccs == sar_pkg::CCS_DL_SEG) || (req.ccs == sar_pkg::CCS_UL_SEG);
    assign is_init = (req.ccs == sar_pkg::CCS_DL_INIT) || (req.ccs == sar_pkg::CCS_UL_INIT);
    assign is_client_abort = (req.ccs == sar_pkg::CCS_ABORT);
    assign timed_out = seg_active_q && (timer_q == TIMEOUT_CYC - 1) && !take && req_ready;
    assign tx_take = tx_valid && tx_ready;

    always_comb begin
        loc = '0;
        chk_eff = '0;
        if (timed_out) begin
            loc.timeout = 1'b1; // RULE_05
        end else if (take && !is_client_abort) begin
            // segment without an open transfer is an unknown command here
            loc.cmd = !(is_seg || is_init) || (is_seg && !seg_active_q); // RULE_05
            loc.toggle = is_seg && seg_active_q && (req.toggle != toggle_exp_q); // RULE_04
            chk_eff = chk;
        end
    end

    sar_code_sel u_sar_code_sel (
        .loc(loc),
        .chk(chk_eff),
        .any(err_any),
        .code(err_code)
    );

    // ----------------------------------------------------------------
    // segmented transfer tracking
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            seg_active_q <= 1'b0;
            toggle_exp_q <= 1'b0;
        end else if (err_any || (take && is_client_abort)) begin
            seg_active_q <= 1'b0; // RULE_02
            toggle_exp_q <= 1'b0;
        end else if (take && is_init) begin
            seg_active_q <= !req.last;
            toggle_exp_q <= 1'b0;
        end else if (take && is_seg) begin
            seg_active_q <= !req.last;
            toggle_exp_q <= !toggle_exp_q; // RULE_04
        end
    end

    // idle time since last request of an open transfer
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            timer_q <= '0;
        end else if (take || !seg_active_q || timed_out) begin
            timer_q <= '0;
        end else if (req_ready) begin
            timer_q <= timer_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            index_q <= '0;
            sub_q <= '0;
        end else if (take && !is_seg) begin
            index_q <= req.index;
            sub_q <= req.subindex;
        end
    end

    // ----------------------------------------------------------------
    // abort frame: cmd, index lo, index hi, subindex, code lo..hi
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_q <= ST_IDLE;
            frame_q <= '0;
            byte_cnt_q <= '0;
            code_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (err_any) begin
                        state_q <= ST_SEND; // RULE_02
                        code_q <= err_code;
                        byte_cnt_q <= '0;
                        // segments do not carry the address, so reuse the open one
                        frame_q <= {err_code, // RULE_01 RULE_13
                                    (take && !is_seg) ? req.subindex : sub_q,
                                    (take && !is_seg) ? req.index : index_q,
                                    sar_pkg::ABORT_CMD};
                    end
                end
                ST_SEND: begin
                    if (tx_take) begin
                        frame_q <= {8'h00, frame_q[63:8]};
                        byte_cnt_q <= byte_cnt_q + 3'h1;
                        if (byte_cnt_q == sar_pkg::LAST_BYTE) begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign tx_valid = (state_q == ST_SEND);
    assign tx_data = frame_q[7:0];

    // normal reply only when nothing went wrong
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            resp_ok_q <= 1'b0;
        end else begin
            resp_ok_q <= take && !is_client_abort && !err_any; // RULE_02
        end
    end
    assign resp_ok = resp_ok_q;

    // ----------------------------------------------------------------
    // emergency producer
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            fault_q <= '0;
        end else begin
            fault_q <= {drive_fault, comm_fault};
        end
    end

    // a new fault edge in the cycle of acceptance keeps the message pending
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            emcy_valid_q <= 1'b0;
            emcy_src_q <= '0;
        end else if (|({drive_fault, comm_fault} & ~fault_q)) begin
            emcy_valid_q <= 1'b1; // RULE_03
            emcy_src_q <= {drive_fault, comm_fault} & ~fault_q;
        end else if (emcy_ready) begin
            emcy_valid_q <= 1'b0;
        end
    end
    assign emcy_valid = emcy_valid_q;
    assign emcy_src = emcy_src_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_abort_cmd_byte: assert property (@(posedge mclk) disable iff (reset) // RULE_02
        tx_valid && byte_cnt_q == 3'h0 |-> tx_data == sar_pkg::ABORT_CMD)
        else $error("abort frame does not open with abort command");
    a_frame_length: assert property (@(posedge mclk) disable iff (reset) // RULE_01
        tx_take && byte_cnt_q == sar_pkg::LAST_BYTE |=> !tx_valid)
        else $error("abort frame not eight bytes long");
    a_code_lsb_first: assert property (@(posedge mclk) disable iff (reset) // RULE_13
        tx_valid && byte_cnt_q == sar_pkg::CODE_BYTE0 |-> tx_data == code_q[7:0])
        else $error("abort code low byte not at byte four");
    a_index_echo: assert property (@(posedge mclk) disable iff (reset) // RULE_13
        tx_valid && byte_cnt_q == sar_pkg::IDX_BYTE0 |-> tx_data == index_q[7:0])
        else $error("index low byte not echoed");
    a_toggle_abort: assert property (@(posedge mclk) disable iff (reset) // RULE_04
        take && is_seg && seg_active_q && req.toggle != toggle_exp_q
        |=> tx_valid && code_q == sar_pkg::CODE_TOGGLE)
        else $error("toggle fault not aborted");
    a_bad_command: assert property (@(posedge mclk) disable iff (reset) // RULE_05
        take && req.ccs > sar_pkg::CCS_ABORT |=> tx_valid && code_q == sar_pkg::CODE_CMD)
        else $error("unknown command not aborted");
    a_timeout_abort: assert property (@(posedge mclk) disable iff (reset) // RULE_05
        timed_out |=> tx_valid && code_q == sar_pkg::CODE_TIMEOUT && !seg_active_q)
        else $error("transfer timeout not aborted");
    a_no_access: assert property (@(posedge mclk) disable iff (reset) // RULE_06
        take && is_init && chk.no_access && !chk.memory
        |=> code_q == sar_pkg::CODE_NO_ACCESS)
        else $error("inaccessible object code wrong");
    a_no_subindex: assert property (@(posedge mclk) disable iff (reset) // RULE_07
        take && is_init && chk == sar_chk_one_sub() |=> code_q == sar_pkg::CODE_NO_SUB)
        else $error("missing subindex code wrong");
    a_ok_excludes_abort: assert property (@(posedge mclk) disable iff (reset) // RULE_02
        $rose(tx_valid) |-> !resp_ok ##1 !resp_ok)
        else $error("normal reply alongside abort");
    a_emcy_raise: assert property (@(posedge mclk) disable iff (reset) // RULE_03
        $rose(comm_fault) || $rose(drive_fault)
        |=> emcy_valid ##1 (emcy_valid || $past(emcy_ready)))
        else $error("fault did not raise emergency");

    function automatic sar_pkg::sar_chk_t sar_chk_one_sub();
        sar_pkg::sar_chk_t c;
        c = '0;
        c.no_sub = 1'b1;
        return c;
    endfunction : sar_chk_one_sub

    c_toggle_abort: cover property (@(posedge mclk) disable iff (reset)
        take && is_seg && seg_active_q && req.toggle != toggle_exp_q);
    c_timeout: cover property (@(posedge mclk) disable iff (reset) timed_out);
    c_full_frame: cover property (@(posedge mclk) disable iff (reset)
        tx_take && byte_cnt_q == sar_pkg::LAST_BYTE);
    c_emergency: cover property (@(posedge mclk) disable iff (reset) emcy_valid && emcy_ready);

endmodule : sar_abort_reporter
`default_nettype wire

// File: src/sar_pkg.sv
package sar_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned SDO_TIMEOUT_MS = 1000;
    localparam int unsigned TIMEOUT_CYC = (CLK_HZ / 1000) * SDO_TIMEOUT_MS;

    // ----------------------------------------------------------------
    // command specifiers and frame layout
    // ----------------------------------------------------------------
    localparam logic [2:0] CCS_DL_SEG = 3'h0;
    localparam logic [2:0] CCS_DL_INIT = 3'h1;
    localparam logic [2:0] CCS_UL_INIT = 3'h2;
    localparam logic [2:0] CCS_UL_SEG = 3'h3;
    localparam logic [2:0] CCS_ABORT = 3'h4;
    localparam logic [7:0] ABORT_CMD = 8'h80;
    localparam int unsigned FRAME_BYTES = 8;
    localparam logic [2:0] LAST_BYTE = 3'h7;
    localparam logic [2:0] CODE_BYTE0 = 3'h4;
    localparam logic [2:0] IDX_BYTE0 = 3'h1;

    // ----------------------------------------------------------------
    // abort codes
    // ----------------------------------------------------------------
    localparam logic [31:0] CODE_TOGGLE = 32'h0503_0000;
    localparam logic [31:0] CODE_TIMEOUT = 32'h0504_0000;
    localparam logic [31:0] CODE_CMD = 32'h0504_0001;
    localparam logic [31:0] CODE_MEMORY = 32'h0504_0005;
    localparam logic [31:0] CODE_NO_ACCESS = 32'h0601_0000;
    localparam logic [31:0] CODE_WO_READ = 32'h0601_0001;
    localparam logic [31:0] CODE_RO_WRITE = 32'h0601_0002;
    localparam logic [31:0] CODE_NO_OBJECT = 32'h0602_0000;
    localparam logic [31:0] CODE_MAP_OBJ = 32'h0604_0041;
    localparam logic [31:0] CODE_MAP_LEN = 32'h0604_0042;
    localparam logic [31:0] CODE_TOO_LONG = 32'h0607_0012;
    localparam logic [31:0] CODE_TOO_SHORT = 32'h0607_0013;
    localparam logic [31:0] CODE_NO_SUB = 32'h0609_0011;
    localparam logic [31:0] CODE_RANGE = 32'h0609_0030;
    localparam logic [31:0] CODE_HIGH = 32'h0609_0031;
    localparam logic [31:0] CODE_LOW = 32'h0609_0032;
    localparam logic [31:0] CODE_MAX_MIN = 32'h0609_0036;
    localparam logic [31:0] CODE_GENERAL = 32'h0800_0000;
    localparam logic [31:0] CODE_APP = 32'h0800_0020;
    localparam logic [31:0] CODE_APP_LOCAL = 32'h0800_0021;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] ccs;
        logic toggle;
        logic last;
        logic [15:0] index;
        logic [7:0] subindex;
    } sar_req_t;

    typedef struct packed {
        logic memory;
        logic no_access;
        logic wo_read;
        logic ro_write;
        logic no_object;
        logic no_sub;
        logic map_obj;
        logic map_len;
        logic too_long;
        logic too_short;
        logic range;
        logic high;
        logic low;
        logic max_min;
        logic app;
        logic app_local;
        logic general;
    } sar_chk_t;

    typedef struct packed {
        logic toggle;
        logic timeout;
        logic cmd;
    } sar_local_t;

endpackage : sar_pkg

// File: src/sar_code_sel.sv
`timescale 1ns/1ns
`default_nettype none
module sar_code_sel (
    input wire sar_pkg::sar_local_t loc,
    input wire sar_pkg::sar_chk_t chk,
    output logic any,
    output logic [31:0] code
);

    // ----------------------------------------------------------------
    // priority: protocol faults before dictionary faults, general last
    // ----------------------------------------------------------------
    function automatic logic [31:0] pick(input sar_pkg::sar_local_t l,
                                         input sar_pkg::sar_chk_t c);
        if (l.toggle) pick = sar_pkg::CODE_TOGGLE; // RULE_04
        else if (l.timeout) pick = sar_pkg::CODE_TIMEOUT; // RULE_05
        else if (l.cmd) pick = sar_pkg::CODE_CMD; // RULE_05
        else if (c.memory) pick = sar_pkg::CODE_MEMORY; // RULE_05
        else if (c.no_access) pick = sar_pkg::CODE_NO_ACCESS; // RULE_06
        else if (c.wo_read) pick = sar_pkg::CODE_WO_READ; // RULE_06
        else if (c.ro_write) pick = sar_pkg::CODE_RO_WRITE; // RULE_06
        else if (c.no_object) pick = sar_pkg::CODE_NO_OBJECT; // RULE_07
        else if (c.no_sub) pick = sar_pkg::CODE_NO_SUB; // RULE_07
        else if (c.map_obj) pick = sar_pkg::CODE_MAP_OBJ; // RULE_08
        else if (c.map_len) pick = sar_pkg::CODE_MAP_LEN; // RULE_08
        else if (c.too_long) pick = sar_pkg::CODE_TOO_LONG; // RULE_09
        else if (c.too_short) pick = sar_pkg::CODE_TOO_SHORT; // RULE_09
        else if (c.high) pick = sar_pkg::CODE_HIGH; // RULE_10
        else if (c.low) pick = sar_pkg::CODE_LOW; // RULE_10
        else if (c.range) pick = sar_pkg::CODE_RANGE; // RULE_10
        else if (c.max_min) pick = sar_pkg::CODE_MAX_MIN; // RULE_11
        else if (c.app_local) pick = sar_pkg::CODE_APP_LOCAL; // RULE_12
        else if (c.app) pick = sar_pkg::CODE_APP; // RULE_12
        else pick = sar_pkg::CODE_GENERAL; // RULE_12
    endfunction : pick

    assign any = (|loc) | (|chk);
    assign code = pick(loc, chk);

endmodule : sar_code_sel
`default_nettype wire

// File: bench/sar_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module sar_master_model (
    input wire logic mclk,
    input wire logic reset,
    input wire logic stall,
    input wire logic clr,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic [63:0] frame,
    output logic [3:0] nbytes
);
    // ----------------------------------------------------------------
    // abort frame sink
    // ----------------------------------------------------------------
    // slow mode drops ready every other cycle so the sender must hold its byte
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= stall ? ~tx_ready : 1'b1;
        end
    end

    // bytes enter at the top, so the first byte ends at the bottom
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            frame <= 64'h0000_0000_0000_0000;
            nbytes <= 4'h0;
        end else if (clr) begin
            nbytes <= 4'h0;
        end else if (tx_valid && tx_ready) begin
            frame <= {tx_data, frame[63:8]};
            nbytes <= nbytes + 4'h1;
        end
    end
endmodule : sar_master_model
`default_nettype wire

// File: bench/sar_abort_reporter_tb.sv
`timescale 1ns/1ns
`default_nettype none
module sar_abort_reporter_tb;
    localparam int unsigned TO_CYC = 20;
    localparam logic [31:0] NONE = 32'h0000_0000;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic req_valid = 1'b0;
    sar_pkg::sar_req_t req = '0;
    sar_pkg::sar_chk_t chk = '0;
    logic comm_fault = 1'b0;
    logic drive_fault = 1'b0;
    logic emcy_ready = 1'b0;
    logic stall = 1'b0;
    logic clr = 1'b0;
    logic req_ready, resp_ok, tx_valid, tx_ready, emcy_valid;
    logic [7:0] tx_data;
    logic [1:0] emcy_src;
    logic [63:0] frame;
    logic [3:0] nbytes;
    logic [15:0] idx = 16'h2a5c;
    logic [7:0] sub = 8'h07;
    logic [31:0] codes [17];
    int bad_count = 0;
    int samples_checked = 0;

    always #5 mclk = ~mclk;

    sar_abort_reporter #(.TIMEOUT_CYC(TO_CYC)) u_sar_abort_reporter (
        .mclk(mclk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .chk(chk), .resp_ok(resp_ok), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .comm_fault(comm_fault),
        .drive_fault(drive_fault), .emcy_valid(emcy_valid),
        .emcy_ready(emcy_ready), .emcy_src(emcy_src)
    );

    sar_master_model u_sar_master_model (
        .mclk(mclk), .reset(reset), .stall(stall), .clr(clr), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .frame(frame), .nbytes(nbytes)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic hang();
        bad_count++;
        $display("Error at %0t: wait ran out", $time);
        end_of_test();
    endtask : hang

    task automatic wait_frame(input logic [31:0] code);
        int n;
        n = 0;
        while (nbytes !== 4'h8 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        if (n == 200) hang();
        check(frame, {code, sub, idx, sar_pkg::ABORT_CMD});
        check({tx_valid, req_ready}, 2'b01);
    endtask : wait_frame

    // NONE as code means no abort frame: a normal reply, or for a client abort (ccs 4) no reply at all
    task automatic xfer(input logic [2:0] ccs, input logic tog, input logic lst,
            input sar_pkg::sar_chk_t c, input logic [31:0] code);
        logic took;
        took = 1'b0;
        @(posedge mclk);
        clr <= 1'b1;
        req_valid <= 1'b1;
        req <= sar_pkg::sar_req_t'({ccs, tog, lst, idx, sub});
        chk <= c;
        for (int i = 0; i < 50 && !took; i++) begin
            @(negedge mclk);
            took = req_ready;
            @(posedge mclk);
            clr <= 1'b0;
        end
        if (!took) hang();
        // released lines show garbage, not the last request
        req_valid <= 1'b0;
        req <= ~req;
        chk <= ~chk;
        @(negedge mclk);
        check({resp_ok, tx_valid, req_ready},
            {code == NONE && ccs != 3'h4, code != NONE, code == NONE});
        if (code != NONE) wait_frame(code);
    endtask : xfer

    task automatic emcy(input logic cf, input logic df, input logic [1:0] src);
        @(posedge mclk);
        comm_fault <= cf;
        drive_fault <= df;
        @(posedge mclk);
        repeat (3) begin
            @(negedge mclk);
            check({emcy_valid, emcy_src}, {1'b1, src});
        end
        @(posedge mclk);
        emcy_ready <= 1'b1;
        @(posedge mclk);
        emcy_ready <= 1'b0;
        comm_fault <= 1'b0;
        drive_fault <= 1'b0;
        repeat (3) @(negedge mclk);
        check(emcy_valid, 1'b0);
    endtask : emcy

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        codes = '{sar_pkg::CODE_MEMORY, sar_pkg::CODE_NO_ACCESS, sar_pkg::CODE_WO_READ,
            sar_pkg::CODE_RO_WRITE, sar_pkg::CODE_NO_OBJECT, sar_pkg::CODE_NO_SUB,
            sar_pkg::CODE_MAP_OBJ, sar_pkg::CODE_MAP_LEN, sar_pkg::CODE_TOO_LONG,
            sar_pkg::CODE_TOO_SHORT, sar_pkg::CODE_RANGE, sar_pkg::CODE_HIGH,
            sar_pkg::CODE_LOW, sar_pkg::CODE_MAX_MIN, sar_pkg::CODE_APP,
            sar_pkg::CODE_APP_LOCAL, sar_pkg::CODE_GENERAL};
        repeat (8) @(posedge mclk);
        check({req_ready, tx_valid, resp_ok, emcy_valid, emcy_src}, 6'h20);
        reset <= 1'b0;
        xfer(3'h1, 1'b0, 1'b1, '0, NONE);
        // one fault flag per row, slow sink on odd rows
        for (int k = 0; k < 17; k++) begin
            @(posedge mclk);
            stall <= k[0];
            xfer(k[0] ? 3'h2 : 3'h1, 1'b0, 1'b1, sar_pkg::sar_chk_t'(17'h1_0000 >> k),
                codes[k]);
        end
        // ------------------------------------------------------------
        // awkward cases
        // ------------------------------------------------------------
        xfer(3'h1, 1'b0, 1'b1, sar_pkg::sar_chk_t'(17'h0_0070), sar_pkg::CODE_HIGH);
        for (int c = 5; c < 8; c++) begin
            xfer(3'(c), 1'b0, 1'b1, '0, sar_pkg::CODE_CMD);
        end
        xfer(3'h0, 1'b0, 1'b1, '0, sar_pkg::CODE_CMD);
        xfer(3'h1, 1'b0, 1'b0, '0, NONE);
        xfer(3'h0, 1'b0, 1'b0, '0, NONE);
        xfer(3'h0, 1'b1, 1'b0, '0, NONE);
        xfer(3'h0, 1'b1, 1'b0, '0, sar_pkg::CODE_TOGGLE);
        xfer(3'h1, 1'b0, 1'b0, '0, NONE);
        xfer(3'h4, 1'b0, 1'b0, '0, NONE);
        xfer(3'h0, 1'b0, 1'b1, '0, sar_pkg::CODE_CMD);
        // open transfer left idle until the watchdog fires
        xfer(3'h1, 1'b0, 1'b0, '0, NONE);
        // sink count was already cleared by the clr pulse of the last xfer, clear it once more
        @(posedge mclk);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        repeat (TO_CYC - 4) @(negedge mclk);
        check(tx_valid, 1'b0);
        wait_frame(sar_pkg::CODE_TIMEOUT);
        emcy(1'b1, 1'b0, 2'b01);
        emcy(1'b0, 1'b1, 2'b10);
        emcy(1'b1, 1'b1, 2'b11);
        // reset in mid-frame must drop the abort
        @(posedge mclk);
        req_valid <= 1'b1;
        req <= sar_pkg::sar_req_t'({3'h5, 2'b01, idx, sub});
        @(posedge mclk);
        req_valid <= 1'b0;
        repeat (2) @(posedge mclk);
        reset <= 1'b1;
        @(negedge mclk);
        check({tx_valid, req_ready, emcy_valid}, 3'b010);
        @(posedge mclk);
        reset <= 1'b0;
        xfer(3'h1, 1'b0, 1'b1, '0, NONE);
        end_of_test();
    end
endmodule : sar_abort_reporter_tb
`default_nettype wire
